// File: src/eecpm_loader.sv
// module: serial-memory preload of per-port configuration fields
// Function
// - word 02h becomes vendor id
// - words 08h/0Ah become subsystem vendor/subsystem id
// - 06h bit0 to 144h bit0, ports 0-2
// - 06h[3:1] to CCh[14:12], all ports
// - 06h[6:4] to CCh[17:15], all ports
// - 06h bits 8,9 to 74h bits 5,6
// - 06h[14:10] to 74h[4:0] switch mode
// - 06h bit15 to 3Ch bit8, ports 1-2
// - 0Ch[1:0] to C4h[1:0] max payload
// - 0Ch[3:2] to CCh[11:10] ASPM
// - 0Ch bit4 to C4h bit15
// - 0Ch bits 5,7 to 70h bits 14,13
// - 0Ch bit6 to 74h bit15
// - 0Ch bit8 to 8Ch bit5
// - 0Ch bit9 to CCh bit21, ports 1-2
// - 0Ch bit10 to 8Ch bit6
// - 0Ch bit11 to 8Ch bit0
// - 0Ch bit12 to CCh bit19
// - 0Ch bit13 to 8Ch bit1
// - 0Ch bit14 to E4h bit12
// - 0Ch bit15 to 8Ch bit3
// - 0Eh margins to 94h, bit15 to E4h bit18
`timescale 1ns/1ns
`default_nettype none

module eecpm_loader
  import eecpm_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // serial-memory word read port
  output logic                        mem_rd_req,
  output logic [7:0]                  mem_addr,
  input  wire logic                   mem_rd_valid,
  input  wire logic [15:0]            mem_rd_data,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // configuration-space side
  output logic                        cfg_ready,
  output logic                        cfg_load_done,
  output logic [15:0]                 vendor_id,
  output logic [15:0]                 subsys_vendor_id,
  output logic [15:0]                 subsys_id,
  output logic [32*NUM_PORTS-1:0]     port_intr_pin_img,
  output logic [32*NUM_PORTS-1:0]     port_cap_dis_img,
  output logic [32*NUM_PORTS-1:0]     port_sw_mode_img,
  output logic [32*NUM_PORTS-1:0]     port_order_ctl_img,
  output logic [32*NUM_PORTS-1:0]     port_tx_margin_img,
  output logic [32*NUM_PORTS-1:0]     port_dev_cap_img,
  output logic [32*NUM_PORTS-1:0]     port_link_cap_img,
  output logic [32*NUM_PORTS-1:0]     port_dev_cap2_img,
  output logic [32*NUM_PORTS-1:0]     port_vc_cap_img
);

  // ------------------------------------------------------------------
  // load sequencer
  // ------------------------------------------------------------------
  eecpm_state_type state_r;
  eecpm_state_type state_nxt;
  logic [2:0]      step_r;
  logic [2:0]      step_nxt;
  logic [15:0]     word_r [1:NUM_WORDS];
  logic            sig_ok_r;
  logic            sig_bad_r;
  logic            done_pulse_r;
  logic            reload_r;
  logic [7:0]      addr_r;

  wire logic       rd_hit    = (state_r == ST_READ) && mem_rd_valid;
  wire logic       sig_match = (mem_rd_data == SIG_EXPECTED);
  wire logic       last_step = (step_r == STEP_W0E);
  wire logic       sig_fail  = rd_hit && (step_r == STEP_SIG) && !sig_match;

  // step to memory address
  function automatic logic [7:0] step_addr(input logic [2:0] s);
    case (s)
      STEP_SIG: step_addr = EE_ADDR_SIG;
      STEP_VID: step_addr = EE_ADDR_VID;
      STEP_W06: step_addr = EE_ADDR_W06;
      STEP_SSV: step_addr = EE_ADDR_SSV;
      STEP_SSI: step_addr = EE_ADDR_SSI;
      STEP_W0C: step_addr = EE_ADDR_W0C;
      default:  step_addr = EE_ADDR_W0E;
    endcase
  endfunction : step_addr

  // next state: start, read words in order, then settle in done
  always_comb begin
    state_nxt = state_r;
    step_nxt  = step_r;
    case (state_r)
      ST_START: begin
        state_nxt = ST_READ;
        step_nxt  = STEP_SIG;
      end
      ST_READ: begin
        if (rd_hit) begin
          if (sig_fail || last_step) begin
            state_nxt = ST_DONE;
          end else begin
            step_nxt = step_r + 3'h1;
          end
        end
      end
      ST_DONE: begin
        if (reload_r) begin
          state_nxt = ST_START;
        end
      end
      default: state_nxt = ST_START;
    endcase
  end

  // sequencer starts itself at reset release
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= ST_START;
      step_r  <= STEP_SIG;
      addr_r  <= EE_ADDR_SIG;
    end else begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      addr_r  <= step_addr(step_nxt);
    end
  end

  // stored words: defaults on reset and at every load start
  always_ff @(posedge sys_clk) begin
    if (reset || state_r == ST_START) begin
      word_r[STEP_VID] <= DEF_VID;
      word_r[STEP_W06] <= DEF_W06;
      word_r[STEP_SSV] <= DEF_SSV;
      word_r[STEP_SSI] <= DEF_SSI;
      word_r[STEP_W0C] <= DEF_W0C;
      word_r[STEP_W0E] <= DEF_W0E;
    end else if (rd_hit && step_r != STEP_SIG) begin
      word_r[step_r] <= mem_rd_data;
    end
  end

  // status flags, done pulse
  always_ff @(posedge sys_clk) begin
    if (reset || state_r == ST_START) begin
      sig_ok_r     <= 1'b0;
      sig_bad_r    <= 1'b0;
      done_pulse_r <= 1'b0;
    end else begin
      if (rd_hit && step_r == STEP_SIG) begin
        sig_ok_r  <= sig_match;
        sig_bad_r <= !sig_match;
      end
      done_pulse_r <= (state_r == ST_READ) && (state_nxt == ST_DONE);
    end
  end

  // request held level-wise until the word comes back
  assign mem_rd_req    = (state_r == ST_READ);
  assign mem_addr      = addr_r;
  // config accesses wait for the load
  assign cfg_ready     = (state_r == ST_DONE);
  assign cfg_load_done = done_pulse_r;

  // ------------------------------------------------------------------
  // field mapping
  // ------------------------------------------------------------------
  wire logic [15:0] w06 = word_r[STEP_W06];
  wire logic [15:0] w0c = word_r[STEP_W0C];
  wire logic [15:0] w0e = word_r[STEP_W0E];

  assign vendor_id        = word_r[STEP_VID];
  assign subsys_vendor_id = word_r[STEP_SSV];
  assign subsys_id        = word_r[STEP_SSI];

  logic [31:0] img_cap_dis;
  logic [31:0] img_sw_mode;
  logic [31:0] img_order;
  logic [31:0] img_margin;
  logic [31:0] img_dev_cap;
  logic [31:0] img_link_cap;
  logic [31:0] img_dev_cap2;
  logic [31:0] img_vc_cap;

  // images shared by every port; unmapped bits stay zero
  always_comb begin
    img_cap_dis  = 32'h00000000;
    img_sw_mode  = 32'h00000000;
    img_order    = 32'h00000000;
    img_margin   = 32'h00000000;
    img_dev_cap  = 32'h00000000;
    img_link_cap = 32'h00000000;
    img_dev_cap2 = 32'h00000000;
    img_vc_cap   = 32'h00000000;
    img_vc_cap[R144_EVC] = w06[W06_EVC];
    img_link_cap[RCC_L0S +: 3] = w06[W06_L0S +: 3];
    img_link_cap[RCC_L1 +: 3] = w06[W06_L1 +: 3];
    img_sw_mode[R74_NOORD_EGR] = w06[W06_NOORD_EGR];
    img_sw_mode[R74_NOORD_TAG] = w06[W06_NOORD_TAG];
    img_sw_mode[R74_SAF]      = w06[W06_SAF];
    img_sw_mode[R74_CUT +: 2] = w06[W06_CUT +: 2];
    img_sw_mode[R74_ARB]      = w06[W06_ARB];
    img_sw_mode[R74_CRD]      = w06[W06_CRD];
    img_dev_cap[RC4_MPS +: 2] = w0c[W0C_MPS +: 2];
    img_link_cap[RCC_ASPM +: 2] = w0c[W0C_ASPM +: 2];
    img_dev_cap[RC4_RBER] = w0c[W0C_RBER];
    img_cap_dis[R70_MSI_DIS] = w0c[W0C_MSI_DIS];
    img_cap_dis[R70_PM_DIS]  = w0c[W0C_PM_DIS];
    img_sw_mode[R74_CPP_DIS] = w0c[W0C_CPP_DIS];
    img_order[R8C_PPNP] = w0c[W0C_PPNP];
    img_order[R8C_FRZ] = w0c[W0C_FRZ];
    img_order[R8C_SOFL] = w0c[W0C_SOFL];
    img_link_cap[RCC_SDN] = w0c[W0C_SDN];
    img_order[R8C_PMDS] = w0c[W0C_PMDS];
    img_dev_cap2[RE4_LTR] = w0c[W0C_LTR];
    img_order[R8C_4KB] = w0c[W0C_4KB];
    img_margin[R94_DRV_LO +: 5]   = w0e[W0E_DRV_LO +: 5];
    img_margin[R94_DRV_HALF +: 5] = w0e[W0E_DRV_HALF +: 5];
    img_dev_cap2[RE4_OBFF]        = w0e[W0E_OBFF];
  end

  // per-port fan-out; port 0 lacks interrupt pin and bandwidth bit
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      wire logic down_port = (gp != 0);
      logic [31:0] intr_img;
      logic [31:0] link_img;
      always_comb begin
        intr_img = 32'h00000000;
        link_img = img_link_cap;
        intr_img[R3C_INTA] = down_port & w06[W06_INTA];
        link_img[RCC_LBN] = down_port & w0c[W0C_LBN];
      end
      // shared images fanned into every port; interrupt pin and link cap images are per port
      assign port_intr_pin_img[32*gp +: 32]  = intr_img;
      assign port_link_cap_img[32*gp +: 32]  = link_img;
      assign port_cap_dis_img[32*gp +: 32]   = img_cap_dis;
      assign port_sw_mode_img[32*gp +: 32]   = img_sw_mode;
      assign port_order_ctl_img[32*gp +: 32] = img_order;
      assign port_tx_margin_img[32*gp +: 32] = img_margin;
      assign port_dev_cap_img[32*gp +: 32]   = img_dev_cap;
      assign port_dev_cap2_img[32*gp +: 32]  = img_dev_cap2;
      assign port_vc_cap_img[32*gp +: 32]    = img_vc_cap;
    end
  endgenerate

  // ------------------------------------------------------------------
  // wishbone slave: one wait state, ack for any address
  // ------------------------------------------------------------------
  logic        ack_r;
  logic [31:0] rdat_r;
  wire logic   wb_req    = wb_cyc_i && wb_stb_i && !ack_r;
  wire logic   ctrl_wr   = wb_req && wb_we_i && (wb_adr_i == WB_CTRL) && wb_sel_i[0];
  wire logic   busy      = (state_r != ST_DONE);
  logic [31:0] rd_mux;

  // read decode; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      WB_STATUS: begin
        rd_mux[ST_BIT_DONE]   = !busy;
        rd_mux[ST_BIT_SIGOK]  = sig_ok_r;
        rd_mux[ST_BIT_BUSY]   = busy;
        rd_mux[ST_BIT_SIGBAD] = sig_bad_r;
      end
      WB_VID:    rd_mux = {16'h0000, word_r[STEP_VID]};
      WB_SUBSYS: rd_mux = {word_r[STEP_SSI], word_r[STEP_SSV]};
      WB_W06W0C: rd_mux = {w0c, w06};
      WB_W0E:    rd_mux = {16'h0000, w0e};
      default:   rd_mux = 32'h00000000;
    endcase
  end

  // ack and read data registered; reload ignored while busy
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_r    <= 1'b0;
      rdat_r   <= 32'h00000000;
      reload_r <= 1'b0;
    end else begin
      ack_r    <= wb_req;
      rdat_r   <= wb_req ? rd_mux : rdat_r;
      reload_r <= ctrl_wr && wb_dat_i[CTRL_BIT_RELOAD] && !busy;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_sig_bad;
    (state_r == ST_READ) && mem_rd_valid && (step_r == STEP_SIG) && (mem_rd_data != SIG_EXPECTED);
  endsequence
  sequence s_load(logic [2:0] s);
    (state_r == ST_READ) && mem_rd_valid && (step_r == s);
  endsequence

  AST_SIG_BAD_DEFAULTS: assert property (
    s_sig_bad |=> (cfg_ready && (w06 == DEF_W06) && (w0c == DEF_W0C) && sig_bad_r) [*2])
    else $error("bad signature did not end load with defaults");
  AST_READY_WAITS_LOAD: assert property (
    (state_r == ST_START) |=> !cfg_ready && mem_rd_req && (mem_addr == EE_ADDR_SIG))
    else $error("load did not start at the signature with config held off");
  // ready only once the last word or a bad signature was taken
  AST_READY_AFTER_LAST: assert property (
    $rose(cfg_ready) |-> $past(rd_hit) && ($past(last_step) || $past(sig_fail)))
    else $error("config ready rose before the load ended");
  AST_REQ_HELD: assert property (
    mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_addr))
    else $error("memory request dropped before answer");
  AST_VID_COPY: assert property (
    s_load(STEP_VID) |=> vendor_id == $past(mem_rd_data))
    else $error("vendor id not copied");
  AST_SUBSYS_COPY: assert property (
    s_load(STEP_SSI) |=> (subsys_id == $past(mem_rd_data)) ##1 $stable(subsys_vendor_id))
    else $error("subsystem id not copied");
  AST_W06_MAP: assert property (
    s_load(STEP_W06) |=> (port_link_cap_img[17:12] == $past(mem_rd_data[6:1]))
      && (port_sw_mode_img[6:0] == {$past(mem_rd_data[9:8]), $past(mem_rd_data[14:10])})
      && (port_vc_cap_img[0] == $past(mem_rd_data[0])))
    else $error("word 06h fields misplaced");
  AST_INTA_PORTS: assert property (
    (port_intr_pin_img[8] == 1'b0) && (port_intr_pin_img[40] == w06[15]))
    else $error("interrupt pin wrong for port");
  AST_W0C_MAP: assert property (
    s_load(STEP_W0C) |=> ({port_dev_cap_img[15], port_dev_cap_img[1:0], port_link_cap_img[11:10],
      port_cap_dis_img[14:13], port_sw_mode_img[15], port_order_ctl_img[6:5], port_order_ctl_img[3],
      port_order_ctl_img[1:0], port_link_cap_img[19], port_dev_cap2_img[12]}
      == {$past(mem_rd_data[4]), $past(mem_rd_data[1:0]), $past(mem_rd_data[3:2]), $past(mem_rd_data[5]),
      $past(mem_rd_data[7]), $past(mem_rd_data[6]), $past(mem_rd_data[10]), $past(mem_rd_data[8]),
      $past(mem_rd_data[15]), $past(mem_rd_data[13]), $past(mem_rd_data[11]), $past(mem_rd_data[12]),
      $past(mem_rd_data[14])}))
    else $error("word 0Ch fields misplaced");
  AST_LBN_PORTS: assert property (
    s_load(STEP_W0C) |=> !port_link_cap_img[21] && (port_link_cap_img[53] == $past(mem_rd_data[9])))
    else $error("bandwidth notification wrong for port");
  AST_W0E_MAP: assert property (
    s_load(STEP_W0E) |=> (port_tx_margin_img[14:0] == {$past(mem_rd_data[14:10]), 5'h00, $past(mem_rd_data[4:0])})
      && (port_dev_cap2_img[18] == $past(mem_rd_data[15])))
    else $error("word 0Eh fields misplaced");
  AST_PORTS_EQUAL: assert property (
    (port_order_ctl_img[31:0] == port_order_ctl_img[95:64]) && (port_link_cap_img[20:0] == port_link_cap_img[84:64]))
    else $error("ports disagree on shared field");
  AST_WB_ACK_ONE: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not one cycle");

endmodule : eecpm_loader

`default_nettype wire

// File: src/eecpm_pkg.sv
// package: constants of the serial-memory configuration preload map
package eecpm_pkg;

  // ------------------------------------------------------------------
  // memory word addresses (byte addresses of 16-bit words)
  // ------------------------------------------------------------------
  localparam logic [7:0] EE_ADDR_SIG = 8'h00;
  localparam logic [7:0] EE_ADDR_VID = 8'h02;
  localparam logic [7:0] EE_ADDR_W06 = 8'h06;
  localparam logic [7:0] EE_ADDR_SSV = 8'h08;
  localparam logic [7:0] EE_ADDR_SSI = 8'h0A;
  localparam logic [7:0] EE_ADDR_W0C = 8'h0C;
  localparam logic [7:0] EE_ADDR_W0E = 8'h0E;

  // load steps: step 0 is the signature, steps 1..6 are stored words
  localparam logic [2:0] STEP_SIG = 3'h0;
  localparam logic [2:0] STEP_VID = 3'h1;
  localparam logic [2:0] STEP_W06 = 3'h2;
  localparam logic [2:0] STEP_SSV = 3'h3;
  localparam logic [2:0] STEP_SSI = 3'h4;
  localparam logic [2:0] STEP_W0C = 3'h5;
  localparam logic [2:0] STEP_W0E = 3'h6;
  localparam int         NUM_WORDS = 6;

  // hardware defaults of the stored words (kept when signature fails)
  localparam logic [15:0] DEF_VID = 16'h0000;
  localparam logic [15:0] DEF_W06 = 16'h0000;
  localparam logic [15:0] DEF_SSV = 16'h0000;
  localparam logic [15:0] DEF_SSI = 16'h0000;
  localparam logic [15:0] DEF_W0C = 16'h0000;
  localparam logic [15:0] DEF_W0E = 16'h0000;

  // ------------------------------------------------------------------
  // field positions: memory bit (W..) and register bit (R..)
  // ------------------------------------------------------------------
  localparam int W06_EVC = 0;      localparam int R144_EVC = 0;
  localparam int W06_L0S = 1;      localparam int RCC_L0S = 12;
  localparam int W06_L1 = 4;       localparam int RCC_L1 = 15;
  localparam int W06_NOORD_EGR = 8; localparam int R74_NOORD_EGR = 5;
  localparam int W06_NOORD_TAG = 9; localparam int R74_NOORD_TAG = 6;
  localparam int W06_SAF = 10;     localparam int R74_SAF = 0;
  localparam int W06_CUT = 11;     localparam int R74_CUT = 1;
  localparam int W06_ARB = 13;     localparam int R74_ARB = 3;
  localparam int W06_CRD = 14;     localparam int R74_CRD = 4;
  localparam int W06_INTA = 15;    localparam int R3C_INTA = 8;
  localparam int W0C_MPS = 0;      localparam int RC4_MPS = 0;
  localparam int W0C_ASPM = 2;     localparam int RCC_ASPM = 10;
  localparam int W0C_RBER = 4;     localparam int RC4_RBER = 15;
  localparam int W0C_MSI_DIS = 5;  localparam int R70_MSI_DIS = 14;
  localparam int W0C_CPP_DIS = 6;  localparam int R74_CPP_DIS = 15;
  localparam int W0C_PM_DIS = 7;   localparam int R70_PM_DIS = 13;
  localparam int W0C_PPNP = 8;     localparam int R8C_PPNP = 5;
  localparam int W0C_LBN = 9;      localparam int RCC_LBN = 21;
  localparam int W0C_FRZ = 10;     localparam int R8C_FRZ = 6;
  localparam int W0C_SOFL = 11;    localparam int R8C_SOFL = 0;
  localparam int W0C_SDN = 12;     localparam int RCC_SDN = 19;
  localparam int W0C_PMDS = 13;    localparam int R8C_PMDS = 1;
  localparam int W0C_LTR = 14;     localparam int RE4_LTR = 12;
  localparam int W0C_4KB = 15;     localparam int R8C_4KB = 3;
  localparam int W0E_DRV_LO = 0;   localparam int R94_DRV_LO = 0;
  localparam int W0E_DRV_HALF = 10; localparam int R94_DRV_HALF = 10;
  localparam int W0E_OBFF = 15;    localparam int RE4_OBFF = 18;

  // ------------------------------------------------------------------
  // wishbone register offsets and bits
  // ------------------------------------------------------------------
  localparam logic [7:0] WB_STATUS = 8'h00;
  localparam logic [7:0] WB_CTRL   = 8'h04;
  localparam logic [7:0] WB_VID    = 8'h08;
  localparam logic [7:0] WB_SUBSYS = 8'h0C;
  localparam logic [7:0] WB_W06W0C = 8'h10;
  localparam logic [7:0] WB_W0E    = 8'h14;
  localparam int ST_BIT_DONE = 0;
  localparam int ST_BIT_SIGOK = 1;
  localparam int ST_BIT_BUSY = 2;
  localparam int ST_BIT_SIGBAD = 3;
  localparam int CTRL_BIT_RELOAD = 0;

  // expected signature: value is arbitrary
  localparam logic [15:0] SIG_EXPECTED = 16'hA55A;

  typedef enum logic [1:0] {ST_START, ST_READ, ST_DONE} eecpm_state_type;

endpackage : eecpm_pkg

// File: verif/eecpm_loader_bench.sv
// file: self-checking bench of the serial-memory configuration preload
`timescale 1ns/1ns
`default_nettype none

module eecpm_loader_bench
  import eecpm_pkg::*;
();
  logic             sys_clk, reset, wb_cyc, wb_stb, wb_we;
  logic [7:0]       wb_adr;
  logic [31:0]      wb_dat, rd;
  logic [3:0]       wb_sel, delay;
  logic [15:0]      words [8];
  wire logic        mem_rd_req, mem_rd_valid, wb_ack_o, cfg_ready, cfg_load_done;
  wire logic [7:0]  mem_addr;
  wire logic [15:0] mem_rd_data, vendor_id, subsys_vendor_id, subsys_id;
  wire logic [31:0] wb_dat_o;
  wire logic [95:0] img [9];
  int               miscompares, num_checks, cycles, done_cnt;
  logic [7:0]       taken_q [$];

  eecpm_loader u_dut (.sys_clk(sys_clk), .reset(reset), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cfg_ready(cfg_ready), .cfg_load_done(cfg_load_done), .vendor_id(vendor_id),
    .subsys_vendor_id(subsys_vendor_id), .subsys_id(subsys_id), .port_intr_pin_img(img[0]),
    .port_cap_dis_img(img[1]), .port_sw_mode_img(img[2]), .port_order_ctl_img(img[3]),
    .port_tx_margin_img(img[4]), .port_dev_cap_img(img[5]), .port_link_cap_img(img[6]),
    .port_dev_cap2_img(img[7]), .port_vc_cap_img(img[8]));
  eecpm_mem_model u_mem (.sys_clk(sys_clk), .reset(reset), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .delay(delay), .words(words), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

  // ------------------------------------------------------------------
  // clock, watchdog and memory-port monitor
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // the ceiling covers four loads and a few bus cycles with ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (mem_rd_req === 1'b1 && mem_rd_valid === 1'b1) taken_q.push_back(mem_addr);
    if (cfg_load_done === 1'b1) done_cnt++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge sys_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, adr, wd};
    // hold the request until ack; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    @(posedge sys_clk);
  endtask : wb_xfer

  task automatic wait_ready();
    while (cfg_ready !== 1'b1) begin
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask : wait_ready

  // expected register image k of port p, built from the stored words
  function automatic logic [31:0] exp_img(int k, int p, logic [15:0] a, logic [15:0] c, logic [15:0] e);
    logic hi;
    hi = (p > 0);
    case (k)
      0: return {23'h0, a[15] & hi, 8'h0};
      1: return {17'h0, c[5], c[7], 13'h0};
      2: return {16'h0, c[6], 8'h0, a[9:8], a[14:10]};
      3: return {25'h0, c[10], c[8], 1'b0, c[15], 1'b0, c[13], c[11]};
      4: return {17'h0, e[14:10], 5'h0, e[4:0]};
      5: return {16'h0, c[4], 13'h0, c[1:0]};
      6: return {10'h0, c[9] & hi, 1'b0, c[12], 1'b0, a[6:4], a[3:1], c[3:2], 10'h0};
      7: return {13'h0, e[15], 5'h0, c[14], 12'h0};
      default: return {31'h0, a[0]};
    endcase
  endfunction : exp_img

  task automatic check_load(input logic good);
    logic [15:0] a, c, e;
    logic [7:0]  order [7];
    order = '{8'h00, 8'h02, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E};
    a = good ? words[3] : DEF_W06;
    c = good ? words[6] : DEF_W0C;
    e = good ? words[7] : DEF_W0E;
    for (int k = 0; k < 9; k++) begin
      for (int p = 0; p < 3; p++) chk(exp_img(k, p, a, c, e), img[k][32*p +: 32]);
    end
    chk({16'h0, good ? words[1] : DEF_VID}, {16'h0, vendor_id});
    chk(good ? {words[5], words[4]} : {DEF_SSI, DEF_SSV}, {subsys_id, subsys_vendor_id});
    chk(good ? 32'h7 : 32'h1, taken_q.size());
    for (int i = 0; i < taken_q.size() && i < 7; i++) chk({24'h0, order[i]}, {24'h0, taken_q[i]});
    chk(32'h1, done_cnt);
    wb_xfer(1'b0, WB_STATUS, 32'h0);
    chk(good ? 32'h3 : 32'h9, rd);
  endtask : check_load

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_power_up();
    wait_ready();
    check_load(1'b1);
    $display("test power_up done, mismatches %0d", miscompares);
  endtask : t_power_up

  task automatic t_bus_regs();
    wb_xfer(1'b1, WB_VID, 32'hFFFF_FFFF);
    wb_xfer(1'b0, WB_VID, 32'h0);
    chk({16'h0, words[1]}, rd);
    wb_xfer(1'b0, WB_W06W0C, 32'h0);
    chk({words[6], words[3]}, rd);
    wb_xfer(1'b0, WB_SUBSYS, 32'h0);
    chk({words[5], words[4]}, rd);
    wb_xfer(1'b0, WB_W0E, 32'h0);
    chk({16'h0, words[7]}, rd);
    wb_xfer(1'b0, 8'h20, 32'h0);
    chk(32'h0, rd);
    $display("test bus_regs done, mismatches %0d", miscompares);
  endtask : t_bus_regs

  // reload with a new memory image, answering every read after dly cycles
  task automatic t_reload(input logic [15:0] sig, input logic [15:0] pat, input logic [3:0] dly);
    words[0] <= sig;
    for (int i = 1; i < 8; i++) words[i] <= pat ^ 16'(i);
    delay <= dly;
    @(posedge sys_clk);
    taken_q.delete();
    done_cnt = 0;
    wb_xfer(1'b1, WB_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'h0, {31'h0, cfg_ready});
    wait_ready();
    check_load(sig === SIG_EXPECTED);
    $display("test reload %h done, mismatches %0d", pat, miscompares);
  endtask : t_reload

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    {reset, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel, delay} = {4'b1000, 8'h00, 32'h0, 4'hF, 4'h0};
    words[0] = SIG_EXPECTED;
    for (int i = 1; i < 8; i++) words[i] = 16'h5555 ^ 16'(i);
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_power_up();
    t_bus_regs();
    t_reload(SIG_EXPECTED, 16'hFFF8, 4'h3);
    t_reload(SIG_EXPECTED, 16'hAAAA, 4'h0);
    t_reload(16'hA55B, 16'hFFFF, 4'h1);
    stop_test();
  end
endmodule : eecpm_loader_bench

`default_nettype wire

// File: verif/eecpm_mem_model.sv
// file: behavioural serial configuration memory with adjustable answer delay
`timescale 1ns/1ns
`default_nettype none

module eecpm_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        mem_rd_req,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [3:0]  delay,
  input  wire logic [15:0] words [8],
  output logic             mem_rd_valid,
  output logic [15:0]      mem_rd_data
);
  logic [3:0] wait_r;

  // ------------------------------------------------------------------
  // answer logic
  // ------------------------------------------------------------------
  // data toggles whenever no word is offered, so stale data never passes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_rd_valid <= 1'b0;
      wait_r       <= 4'h0;
      mem_rd_data  <= 16'hC3C3;
    end else if (!mem_rd_req || mem_rd_valid) begin
      mem_rd_valid <= 1'b0;
      wait_r       <= 4'h0;
      mem_rd_data  <= ~mem_rd_data;
    end else if (wait_r >= delay) begin
      mem_rd_valid <= 1'b1;
      mem_rd_data  <= words[mem_addr[3:1]];
    end else begin
      wait_r      <= wait_r + 4'h1;
      mem_rd_data <= ~mem_rd_data;
    end
  end
endmodule : eecpm_mem_model

`default_nettype wire
